// ===== src/rfpc_map.svh
`ifndef RFPC_MAP_SVH
`define RFPC_MAP_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define RFPC_IDX_CHIP 6'h00
`define RFPC_IDX_PROTO 6'h01
`define RFPC_IDX_TXOPT 6'h02
`define RFPC_IDX_RXOPT 6'h03
`define RFPC_IDX_MISC 6'h05
`define RFPC_IDX_RTCAL 6'h08
`define RFPC_IDX_PLLCFG 6'h09
`define RFPC_IDX_ISTAT 6'h0E
`define RFPC_IDX_VCOSTAT 6'h10
`define RFPC_IDX_CPCTL 6'h14
`define RFPC_IDX_MODC 6'h15
`define RFPC_IDX_MAIN 6'h16
`define RFPC_IDX_AUX 6'h17
`define RFPC_IDX_CMD 6'h1F

// ----------------------------------------
// direct commands
// ----------------------------------------
`define RFPC_CMD_HOP_MAIN 8'h84
`define RFPC_CMD_HOP_AUX 8'h85

// ----------------------------------------
// field positions
// ----------------------------------------
`define RFPC_CHIP_RF_FIELD_ENABLE 0
`define RFPC_CHIP_REC_ON 1
`define RFPC_CHIP_AGC_ON 2
`define RFPC_CHIP_AGL_ON 3
`define RFPC_CHIP_DAC_ON 4
`define RFPC_CHIP_DIRECT 5
`define RFPC_CHIP_STBY 6
`define RFPC_PROTO_PROT_LO 2
`define RFPC_PROTO_PROT_HI 5
`define RFPC_PROTO_DIR_MODE 6
`define RFPC_PROTO_RX_CRC_N 7
`define RFPC_MISC_CLOCK_OPEN_DRAIN_SELECT 4
`define RFPC_CP_AUTO 8
`define RFPC_AUX_EXTERNAL_RF_INPUT 20
`define RFPC_AUX_PRESC 21
`define RFPC_AUX_LEV_VCO 22
`define RFPC_ISTAT_OSC_OK 0
`define RFPC_ISTAT_RAMP_DONE 2
`define RFPC_ISTAT_SERIAL 7

// ----------------------------------------
// preset values
// ----------------------------------------
`define RFPC_RST_PROTO 8'h02
`define RFPC_RST_TXOPT 8'hF0
`define RFPC_RST_RXOPT 8'h61
`define RFPC_RST_RTCAL 8'h85
`define RFPC_FIFO_BYTES 24

// ----------------------------------------
// timing
// ----------------------------------------
`define RFPC_MCLK_NS 4
`define RFPC_SYSCLK_HZ 5000000
`define RFPC_MCLK_HZ 250000000
`define RFPC_OSC_SETTLE_NS 1500000
`define RFPC_VCO_SETTLE_NS 2000
`define RFPC_RAMP_TARI0_NS 6250
`define RFPC_RAMP_TARI1_NS 12500
`define RFPC_RAMP_TARI2_NS 25000
`define RFPC_RAMP_T100_NS 100000
`define RFPC_RAMP_T200_NS 200000
`define RFPC_RAMP_T400_NS 400000

`endif

// ===== src/rfpc_pkg.sv
package rfpc_pkg;

  typedef enum logic [1:0] {RAMP_OFF, RAMP_UP, RAMP_ON, RAMP_DOWN} rfpc_ramp_t;
  typedef enum logic {VS_IDLE, VS_WAIT} rfpc_vsel_t;

  // front-end controls driven to the analog blocks
  typedef struct packed {
    logic tx_rx_en;
    logic rec_on;
    logic agc_on;
    logic agl_on;
    logic dac_on;
    logic direct;
    logic stby;
    logic dir_type;
    logic skip_crc;
    logic gen2;
    logic ext_src;
    logic ext_presc;
    logic lev_vco;
    logic [1:0] cp_cur;
    logic cp_inv;
    logic [2:0] osc_bias;
    logic mvco;
  } rfpc_ana_t;

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic en_prev;
    logic vh_s1;
    logic vh_s2;
    logic ss_s1;
    logic ss_s2;
    logic serial_q;
    logic [19:0] osc_cnt;
    logic osc_ok;
    logic [4:0] clk_cnt;
    logic clk_lvl;
    logic clk_out;
    logic clk_oe;
    logic [7:0] chip;
    logic [7:0] proto;
    logic [7:0] txopt;
    logic [7:0] rxopt;
    logic [7:0] misc;
    logic [7:0] rtcal;
    logic [7:0] pllcfg;
    logic [15:0] cpctl;
    logic [7:0] modc;
    logic [23:0] mainr;
    logic [23:0] auxr;
    logic mvco;
    logic [3:0] vco_res;
    logic auto_prev;
    rfpc_vsel_t vstate;
    logic [3:0] aseg;
    logic [1:0] astep;
    logic [11:0] acnt;
    logic use_aux;
    rfpc_ramp_t ramp;
    logic [19:0] rcnt;
    logic ramp_done;
    logic field_on;
    logic ramping;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [16:0] synth_n;
    logic [2:0] ref_sel;
    logic [3:0] vco_seg;
    logic gen2;
    logic ext_presc;
  } rfpc_st_t;

endpackage

// ===== src/rfpc_top.sv
`timescale 1ns/1ps
`include "rfpc_map.svh"
// Function
// - host port is 32-bit APB; serial strap level is only latched into bit 7 of register 0E
// - open-drain bit in register 05 makes system clock output open-drain
// - external-input bit in register 17 selects external RF pin as source
// - external-input plus prescaler bits route external VCO through internal PLL
// - three-bit oscillator bias field in register 14 sets oscillator setting
// - VCO segment manual from register 14 or auto on auto-bit rising edge
// - register 10 holds VCO measure bit and last auto segment result
// - register 16 holds A low, B next; ratio is B*32 plus A*33
// - three-bit field in register 16 selects PLL reference clock
// - two-bit charge-pump current field; bit 3 inverts pump polarity
// - command 85 hops to aux register, 84 to main; inactive one rewritable
// - RF-enable bit enables tx/rx and ramps field up; clear ramps down
// - ramp length follows Tari, slowdown field selects 100, 200, 400 us
// - ramp-done bit in register 0E goes high when ramp-up completes
// - chip status bits enable receiver, AGC, AGL, DAC, direct, standby
// - protocol field bits 5 and 2 both zero in register 01 select Gen2
// - bit 6 of register 01 selects direct-mode output signal type
// - bit 7 of register 01 skips CRC check, CRC passed as data
// - enable pin rising edge presets option registers to default operation
// - after oscillator settles, system clock output starts at 5 MHz
module rfpc_top #(
  parameter int OSC_SETTLE_CYC = `RFPC_OSC_SETTLE_NS / `RFPC_MCLK_NS,
  parameter int RAMP_T100_CYC = `RFPC_RAMP_T100_NS / `RFPC_MCLK_NS,
  parameter int RAMP_T200_CYC = `RFPC_RAMP_T200_NS / `RFPC_MCLK_NS,
  parameter int RAMP_T400_CYC = `RFPC_RAMP_T400_NS / `RFPC_MCLK_NS,
  parameter int RAMP_TARI2_CYC = `RFPC_RAMP_TARI2_NS / `RFPC_MCLK_NS,
  parameter int FIFO_BYTES = `RFPC_FIFO_BYTES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // pins
  input wire logic EN,
  input wire logic SERIAL_STRAP,
  input wire logic VCO_HIGH,
  output logic SYSTEM_CLOCK_OUTPUT_O,
  output logic SYSTEM_CLOCK_OUTPUT_OE,
  // rf field
  output logic RF_FIELD_ON,
  output logic RF_RAMPING,
  // synthesizer
  output logic [16:0] SYNTH_N,
  output logic [2:0] REF_SEL,
  output logic [3:0] VCO_SEG,
  output rfpc_pkg::rfpc_ana_t ANA
);

  // ----------------------------------------
  // constants and helpers
  // ----------------------------------------
  localparam int CLK_HALF = `RFPC_MCLK_HZ / (2 * `RFPC_SYSCLK_HZ);
  localparam int VCO_SETTLE_CYC = `RFPC_VCO_SETTLE_NS / `RFPC_MCLK_NS;
  localparam int TARI0_CYC = `RFPC_RAMP_TARI0_NS / `RFPC_MCLK_NS;
  localparam int TARI1_CYC = `RFPC_RAMP_TARI1_NS / `RFPC_MCLK_NS;

  function automatic logic [16:0] div_ratio(input logic [9:0] a, input logic [9:0] b);
    div_ratio = 17'({7'h00, b} * 17'h00020) + 17'({7'h00, a} * 17'h00021);
  endfunction

  function automatic logic [19:0] ramp_len(input logic [1:0] tari, input logic [1:0] slow);
    int c;
    c = RAMP_TARI2_CYC;
    unique case (slow)
      2'h1: c = RAMP_T100_CYC;
      2'h2: c = RAMP_T200_CYC;
      2'h3: c = RAMP_T400_CYC;
      default: begin
        if (tari == 2'h0) begin
          c = TARI0_CYC;
        end else if (tari == 2'h1) begin
          c = TARI1_CYC;
        end
      end
    endcase
    ramp_len = 20'(c - 1);
  endfunction

  function automatic rfpc_pkg::rfpc_st_t cfg_preset(input rfpc_pkg::rfpc_st_t x);
    rfpc_pkg::rfpc_st_t y;
    y = x;
    y.chip = 8'h00;
    y.proto = `RFPC_RST_PROTO;
    y.txopt = `RFPC_RST_TXOPT;
    y.rxopt = `RFPC_RST_RXOPT;
    y.rtcal = `RFPC_RST_RTCAL;
    y.misc = 8'h00;
    y.pllcfg = 8'h00;
    y.cpctl = 16'h0000;
    y.modc = 8'h00;
    y.mainr = 24'h000000;
    y.auxr = 24'h000000;
    y.mvco = 1'b0;
    y.use_aux = 1'b0;
    y.gen2 = ~y.proto[`RFPC_PROTO_PROT_HI] & ~y.proto[`RFPC_PROTO_PROT_LO];
    y.ext_presc = 1'b0;
    cfg_preset = y;
  endfunction

  localparam rfpc_pkg::rfpc_st_t ST_INIT = cfg_preset('0);

  rfpc_pkg::rfpc_st_t s_q;
  rfpc_pkg::rfpc_st_t s_d;

  logic en_rise;
  logic acc;
  logic take_wr;
  logic hit;
  logic [31:0] rd;
  logic [5:0] idx;
  logic rf_field_enable;
  logic [19:0] rlen;
  logic [23:0] sel_div;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    idx = PADDR[7:2];
    rf_field_enable = s_q.chip[`RFPC_CHIP_RF_FIELD_ENABLE];
    rlen = ramp_len(s_q.proto[1:0], s_q.modc[1:0]);
    // input synchronisers
    s_d.en_s1 = EN;
    s_d.en_s2 = s_q.en_s1;
    s_d.en_prev = s_q.en_s2;
    s_d.vh_s1 = VCO_HIGH;
    s_d.vh_s2 = s_q.vh_s1;
    s_d.ss_s1 = SERIAL_STRAP;
    s_d.ss_s2 = s_q.ss_s1;
    en_rise = s_q.en_s2 & ~s_q.en_prev;

    // register read mux
    hit = 1'b1;
    rd = 32'h00000000;
    unique case (idx)
      `RFPC_IDX_CHIP: rd = {24'h000000, s_q.chip};
      `RFPC_IDX_PROTO: rd = {24'h000000, s_q.proto};
      `RFPC_IDX_TXOPT: rd = {24'h000000, s_q.txopt};
      `RFPC_IDX_RXOPT: rd = {24'h000000, s_q.rxopt};
      `RFPC_IDX_MISC: rd = {24'h000000, s_q.misc};
      `RFPC_IDX_RTCAL: rd = {24'h000000, s_q.rtcal};
      `RFPC_IDX_PLLCFG: rd = {24'h000000, s_q.pllcfg};
      `RFPC_IDX_ISTAT: begin
        rd[`RFPC_ISTAT_OSC_OK] = s_q.osc_ok;
        rd[`RFPC_ISTAT_RAMP_DONE] = s_q.ramp_done;
        rd[`RFPC_ISTAT_SERIAL] = s_q.serial_q;
      end
      `RFPC_IDX_VCOSTAT: rd = {24'h000000, s_q.vco_res, 3'h0, s_q.mvco};
      `RFPC_IDX_CPCTL: rd = {16'h0000, s_q.cpctl};
      `RFPC_IDX_MODC: rd = {24'h000000, s_q.modc};
      `RFPC_IDX_MAIN: rd = {8'h00, s_q.mainr};
      `RFPC_IDX_AUX: rd = {8'h00, s_q.auxr};
      `RFPC_IDX_CMD: rd = {24'h000000, (s_q.use_aux ? `RFPC_CMD_HOP_AUX : `RFPC_CMD_HOP_MAIN)};
      default: hit = 1'b0;
    endcase

    // apb: one wait state, answer registered
    acc = PSEL & PENABLE & ~s_q.pready;
    take_wr = PSEL & PENABLE & s_q.pready & PWRITE & hit;
    s_d.pready = acc;
    s_d.pslverr = acc & ~hit;
    if (acc) begin
      s_d.prdata = PWRITE ? 32'h00000000 : rd;
    end

    // register writes
    if (take_wr) begin
      unique case (idx)
        `RFPC_IDX_CHIP: s_d.chip = {1'b0, PWDATA[6:0]};
        `RFPC_IDX_PROTO: s_d.proto = PWDATA[7:0];
        `RFPC_IDX_TXOPT: s_d.txopt = PWDATA[7:0];
        `RFPC_IDX_RXOPT: s_d.rxopt = PWDATA[7:0];
        `RFPC_IDX_MISC: s_d.misc = PWDATA[7:0];
        `RFPC_IDX_RTCAL: s_d.rtcal = PWDATA[7:0];
        `RFPC_IDX_PLLCFG: s_d.pllcfg = PWDATA[7:0];
        `RFPC_IDX_VCOSTAT: s_d.mvco = PWDATA[0];
        `RFPC_IDX_CPCTL: s_d.cpctl = {4'h0, PWDATA[11:0]};
        `RFPC_IDX_MODC: s_d.modc = PWDATA[7:0];
        `RFPC_IDX_MAIN: s_d.mainr = PWDATA[23:0];
        `RFPC_IDX_AUX: s_d.auxr = PWDATA[23:0];
        `RFPC_IDX_CMD: begin
          if (PWDATA[7:0] == `RFPC_CMD_HOP_AUX) begin
            s_d.use_aux = 1'b1;
          end else if (PWDATA[7:0] == `RFPC_CMD_HOP_MAIN) begin
            s_d.use_aux = 1'b0;
          end
        end
        default: s_d.use_aux = s_q.use_aux;
      endcase
    end

    // oscillator start-up and system clock output
    if (!s_q.en_s2) begin
      s_d.osc_ok = 1'b0;
    end else if (!s_q.osc_ok) begin
      if (s_q.osc_cnt == 20'h00000) begin
        s_d.osc_ok = 1'b1;
      end else begin
        s_d.osc_cnt = s_q.osc_cnt - 20'h00001;
      end
    end
    if (s_q.osc_ok) begin
      if (s_q.clk_cnt == 5'(CLK_HALF - 1)) begin
        s_d.clk_cnt = 5'h00;
        s_d.clk_lvl = ~s_q.clk_lvl;
      end else begin
        s_d.clk_cnt = s_q.clk_cnt + 5'h01;
      end
    end else begin
      s_d.clk_cnt = 5'h00;
      s_d.clk_lvl = 1'b0;
    end
    if (!s_d.osc_ok) begin
      s_d.clk_out = 1'b0;
      s_d.clk_oe = 1'b0;
    end else if (s_q.misc[`RFPC_MISC_CLOCK_OPEN_DRAIN_SELECT]) begin
      s_d.clk_out = 1'b0;
      s_d.clk_oe = ~s_d.clk_lvl;
    end else begin
      s_d.clk_out = s_d.clk_lvl;
      s_d.clk_oe = 1'b1;
    end

    // vco segment auto selection, successive approximation
    s_d.auto_prev = s_q.cpctl[`RFPC_CP_AUTO];
    unique case (s_q.vstate)
      rfpc_pkg::VS_IDLE: begin
        if (s_q.cpctl[`RFPC_CP_AUTO] && !s_q.auto_prev) begin
          s_d.vstate = rfpc_pkg::VS_WAIT;
          s_d.aseg = 4'h8;
          s_d.astep = 2'h3;
          s_d.acnt = 12'(VCO_SETTLE_CYC - 1);
        end
      end
      rfpc_pkg::VS_WAIT: begin
        if (s_q.acnt != 12'h000) begin
          s_d.acnt = s_q.acnt - 12'h001;
        end else begin
          if (!s_q.vh_s2) begin
            s_d.aseg[s_q.astep] = 1'b0;
          end
          if (s_q.astep == 2'h0) begin
            s_d.vco_res = s_d.aseg;
            s_d.vstate = rfpc_pkg::VS_IDLE;
          end else begin
            s_d.astep = s_q.astep - 2'h1;
            s_d.aseg[s_q.astep - 2'h1] = 1'b1;
            s_d.acnt = 12'(VCO_SETTLE_CYC - 1);
          end
        end
      end
    endcase
    if (!s_q.cpctl[`RFPC_CP_AUTO]) begin
      s_d.vco_seg = s_q.cpctl[7:4];
    end else if (s_q.vstate == rfpc_pkg::VS_WAIT) begin
      s_d.vco_seg = s_q.aseg;
    end else begin
      s_d.vco_seg = s_q.vco_res;
    end

    // rf field ramp
    unique case (s_q.ramp)
      rfpc_pkg::RAMP_OFF: begin
        if (rf_field_enable) begin
          s_d.ramp = rfpc_pkg::RAMP_UP;
          s_d.rcnt = rlen;
        end
      end
      rfpc_pkg::RAMP_UP: begin
        if (!rf_field_enable) begin
          s_d.ramp = rfpc_pkg::RAMP_DOWN;
          s_d.rcnt = rlen;
        end else if (s_q.rcnt == 20'h00000) begin
          s_d.ramp = rfpc_pkg::RAMP_ON;
          s_d.ramp_done = 1'b1;
        end else begin
          s_d.rcnt = s_q.rcnt - 20'h00001;
        end
      end
      rfpc_pkg::RAMP_ON: begin
        if (!rf_field_enable) begin
          s_d.ramp = rfpc_pkg::RAMP_DOWN;
          s_d.rcnt = rlen;
          s_d.ramp_done = 1'b0;
        end
      end
      rfpc_pkg::RAMP_DOWN: begin
        if (rf_field_enable) begin
          s_d.ramp = rfpc_pkg::RAMP_UP;
          s_d.rcnt = rlen;
        end else if (s_q.rcnt == 20'h00000) begin
          s_d.ramp = rfpc_pkg::RAMP_OFF;
        end else begin
          s_d.rcnt = s_q.rcnt - 20'h00001;
        end
      end
    endcase
    s_d.field_on = s_d.ramp != rfpc_pkg::RAMP_OFF;
    s_d.ramping = (s_d.ramp == rfpc_pkg::RAMP_UP) || (s_d.ramp == rfpc_pkg::RAMP_DOWN);

    // synthesizer divider from the active register
    sel_div = s_d.use_aux ? s_d.auxr : s_d.mainr;
    s_d.synth_n = div_ratio(sel_div[9:0], sel_div[19:10]);
    s_d.ref_sel = s_d.mainr[22:20];

    // enable pin rising edge: presets and oscillator restart
    if (en_rise) begin
      s_d = cfg_preset(s_d);
      s_d.serial_q = s_q.ss_s2;
      s_d.osc_cnt = 20'(OSC_SETTLE_CYC - 1);
      s_d.osc_ok = 1'b0;
      s_d.ramp = rfpc_pkg::RAMP_OFF;
      s_d.ramp_done = 1'b0;
      s_d.field_on = 1'b0;
      s_d.ramping = 1'b0;
      s_d.clk_out = 1'b0;
      s_d.clk_oe = 1'b0;
    end

    // decoded front-end controls, registered
    s_d.gen2 = ~s_d.proto[`RFPC_PROTO_PROT_HI] & ~s_d.proto[`RFPC_PROTO_PROT_LO];
    s_d.ext_presc = s_d.auxr[`RFPC_AUX_EXTERNAL_RF_INPUT] & s_d.auxr[`RFPC_AUX_PRESC];
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      s_q <= ST_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign PREADY = s_q.pready;
  assign PRDATA = s_q.prdata;
  assign PSLVERR = s_q.pslverr;
  assign SYSTEM_CLOCK_OUTPUT_O = s_q.clk_out;
  assign SYSTEM_CLOCK_OUTPUT_OE = s_q.clk_oe;
  assign RF_FIELD_ON = s_q.field_on;
  assign RF_RAMPING = s_q.ramping;
  assign SYNTH_N = s_q.synth_n;
  assign REF_SEL = s_q.ref_sel;
  assign VCO_SEG = s_q.vco_seg;
  assign ANA.tx_rx_en = s_q.chip[`RFPC_CHIP_RF_FIELD_ENABLE];
  assign ANA.rec_on = s_q.chip[`RFPC_CHIP_REC_ON];
  assign ANA.agc_on = s_q.chip[`RFPC_CHIP_AGC_ON];
  assign ANA.agl_on = s_q.chip[`RFPC_CHIP_AGL_ON];
  assign ANA.dac_on = s_q.chip[`RFPC_CHIP_DAC_ON];
  assign ANA.direct = s_q.chip[`RFPC_CHIP_DIRECT];
  assign ANA.stby = s_q.chip[`RFPC_CHIP_STBY];
  assign ANA.dir_type = s_q.proto[`RFPC_PROTO_DIR_MODE];
  assign ANA.skip_crc = s_q.proto[`RFPC_PROTO_RX_CRC_N];
  assign ANA.gen2 = s_q.gen2;
  assign ANA.ext_src = s_q.auxr[`RFPC_AUX_EXTERNAL_RF_INPUT];
  assign ANA.ext_presc = s_q.ext_presc;
  assign ANA.lev_vco = s_q.auxr[`RFPC_AUX_LEV_VCO];
  assign ANA.cp_cur = s_q.cpctl[1:0];
  assign ANA.cp_inv = s_q.cpctl[3];
  assign ANA.osc_bias = s_q.cpctl[11:9];
  assign ANA.mvco = s_q.mvco;

endmodule

// ===== verif/rfpc_assertions.sv
`timescale 1ns/1ps
module rfpc_chk (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // pins and outputs
  input wire logic EN,
  input wire logic SYSTEM_CLOCK_OUTPUT_O,
  input wire logic SYSTEM_CLOCK_OUTPUT_OE,
  input wire logic RF_FIELD_ON,
  input wire logic RF_RAMPING,
  input wire logic [16:0] SYNTH_N
);
  typedef struct packed {logic ok; logic [16:0] n;} rfpc_aux_t;
  rfpc_aux_t aux_q;
  rfpc_aux_t aux_d;
  logic tk;
  assign tk = PSEL && PENABLE && PREADY && PWRITE;
  // ----------
  // aux divider shadow
  // ----------
  always_comb begin
    aux_d = aux_q;
    if (!EN) begin
      aux_d.ok = 1'b0;
    end
    if (tk && PADDR[7:2] == 6'h17) begin
      aux_d.ok = 1'b1;
      aux_d.n = {2'h0, PWDATA[19:10], 5'h00} + 17'(PWDATA[9:0]) * 17'h00021;
    end
  end
  always_ff @(posedge MCLK) begin
    if (RST) begin
      aux_q <= '0;
    end else begin
      aux_q <= aux_d;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // ----------
  // properties
  // ----------
  property p_wait;
    $rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY;
  endproperty
  a_wait: assert property (p_wait) else $error("no single wait state");
  property p_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_unmapped;
    PSEL && PENABLE && PREADY && PADDR[7:2] == 6'h3F |-> PSLVERR && PRDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_field_up;
    $rose(RF_FIELD_ON) |-> RF_RAMPING;
  endproperty
  a_field_up: assert property (p_field_up) else $error("field on without ramp");
  property p_field_down;
    $fell(RF_FIELD_ON) |-> $past(RF_RAMPING);
  endproperty
  a_field_down: assert property (p_field_down) else $error("field off without ramp");
  property p_ramp_min;
    $rose(RF_RAMPING) |-> RF_RAMPING [*8];
  endproperty
  a_ramp_min: assert property (p_ramp_min) else $error("ramp too short");
  property p_od;
    SYSTEM_CLOCK_OUTPUT_O |-> SYSTEM_CLOCK_OUTPUT_OE;
  endproperty
  a_od: assert property (p_od) else $error("clock high while undriven");
  property p_clk;
    $rose(SYSTEM_CLOCK_OUTPUT_O) && EN |-> (SYSTEM_CLOCK_OUTPUT_O || !EN) [*8];
  endproperty
  a_clk: assert property (p_clk) else $error("clock high phase short");
  property p_en_low;
    !EN [*6] |-> !SYSTEM_CLOCK_OUTPUT_O && !SYSTEM_CLOCK_OUTPUT_OE;
  endproperty
  a_en_low: assert property (p_en_low) else $error("clock out while disabled");
  property p_hop;
    tk && PADDR[7:2] == 6'h1F && PWDATA[7:0] == 8'h85 && aux_q.ok |->
      ##2 SYNTH_N == aux_q.n;
  endproperty
  a_hop: assert property (p_hop) else $error("hop to aux wrong ratio");
  c_ramp: cover property ($rose(RF_FIELD_ON));
  c_err: cover property (PSLVERR);
  c_hop: cover property (tk && PADDR[7:2] == 6'h1F);
endmodule

// ===== verif/rfpc_host.sv
`timescale 1ns/1ps
module rfpc_host (
  // clock
  input wire logic mclk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one word per register, held until ready
  task automatic xfer(input logic w, input logic [5:0] i, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge mclk);
  endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct {logic w; logic [5:0] i; logic [31:0] d; logic [31:0] x; logic e;} rfpc_row_t;
  logic mclk = 1'b0;
  logic rst, en, serial_strap, vco_high, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic system_clock_output_o, system_clock_output_oe, rf_field_on, rf_ramping, e;
  logic [16:0] synth_n;
  logic [2:0] ref_sel;
  logic [3:0] vco_seg;
  rfpc_pkg::rfpc_ana_t ana, ana_x;
  int fail_count = 0;
  int n_compared = 0;
  int rcnt = 0;
  int k, n, m;
  int lens [4] = '{16, 30, 40, 50};
  rfpc_row_t tab [12] = '{
    '{1'b0, 6'h01, 32'h0, 32'h02, 1'b0},
    '{1'b0, 6'h02, 32'h0, 32'hF0, 1'b0},
    '{1'b0, 6'h03, 32'h0, 32'h61, 1'b0},
    '{1'b0, 6'h08, 32'h0, 32'h85, 1'b0},
    '{1'b1, 6'h00, 32'hFE, 32'h7E, 1'b0},
    '{1'b1, 6'h01, 32'hC0, 32'hC0, 1'b0},
    '{1'b1, 6'h05, 32'h10, 32'h10, 1'b0},
    '{1'b1, 6'h14, 32'hF6AB, 32'h6AB, 1'b0},
    '{1'b1, 6'h10, 32'hFF, 32'h01, 1'b0},
    '{1'b1, 6'h16, 32'hFF332005, 32'h332005, 1'b0},
    '{1'b1, 6'h17, 32'h719001, 32'h719001, 1'b0},
    '{1'b1, 6'h3F, 32'h5A, 32'h0, 1'b1}};
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (rf_ramping === 1'b1) rcnt <= rcnt + 1;
  rfpc_top #(.OSC_SETTLE_CYC(20), .RAMP_T100_CYC(30), .RAMP_T200_CYC(40),
    .RAMP_T400_CYC(50), .RAMP_TARI2_CYC(16)) rfpc_top_inst (.MCLK(mclk), .RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .EN(en),
    .SERIAL_STRAP(serial_strap), .VCO_HIGH(vco_high),
    .SYSTEM_CLOCK_OUTPUT_O(system_clock_output_o),
    .SYSTEM_CLOCK_OUTPUT_OE(system_clock_output_oe), .RF_FIELD_ON(rf_field_on),
    .RF_RAMPING(rf_ramping), .SYNTH_N(synth_n), .REF_SEL(ref_sel), .VCO_SEG(vco_seg),
    .ANA(ana));
  rfpc_host rfpc_host_inst (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  // ----------
  // helpers
  // ----------
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    rfpc_host_inst.xfer(1'b1, i, d, r, e);
  endtask
  task automatic rdc(input logic [5:0] i, input logic [31:0] msk, input logic [31:0] x);
    rfpc_host_inst.xfer(1'b0, i, 32'h0, r, e);
    chk((r & msk) === x, "read value");
  endtask
  task automatic ramp(input logic on, input int len);
    int r0;
    r0 = rcnt;
    wr(6'h00, {31'h0, on});
    for (k = 0; k < 10 && rf_ramping !== 1'b1; k++) @(posedge mclk);
    for (k = 0; k < 8000 && rf_ramping !== 1'b0; k++) @(posedge mclk);
    chk(rcnt - r0 >= len - 1 && rcnt - r0 <= len + 1, "ramp length");
    chk(rf_field_on === on && ana.tx_rx_en === on, "field state");
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    $display("BAD %0t watchdog", $time);
    wrap_up();
  end
  // ----------
  // sequence
  // ----------
  initial begin
    rst = 1'b1;
    en = 1'b0;
    serial_strap = 1'b1;
    vco_high = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    en <= 1'b1;
    for (k = 0; k < 200 && system_clock_output_o !== 1'b1; k++) @(posedge mclk);
    for (n = 0; n < 100 && system_clock_output_o === 1'b1; n++) @(posedge mclk);
    chk(n == 25 && system_clock_output_oe === 1'b1, "clock half period");
    rdc(6'h0E, 32'h81, 32'h81);
    $display("test clock done");
    foreach (tab[i]) begin
      if (tab[i].w) rfpc_host_inst.xfer(1'b1, tab[i].i, tab[i].d, r, e);
      chk(e === tab[i].e, "write response");
      rfpc_host_inst.xfer(1'b0, tab[i].i, 32'h0, r, e);
      chk(r === tab[i].x && e === tab[i].e, "read back");
    end
    ana_x = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
              1'b1, 2'h3, 1'b1, 3'h3, 1'b1};
    chk(ana === ana_x, "front-end controls");
    chk(vco_seg === 4'hA && ref_sel === 3'h3, "segment and ref");
    chk(synth_n === 17'h19A5, "main ratio");
    $display("test registers done");
    wr(6'h1F, 32'h85);
    repeat (3) @(posedge mclk);
    chk(synth_n === 17'h0CA1, "aux ratio");
    rdc(6'h1F, 32'hFF, 32'h85);
    wr(6'h16, 32'h332006);
    chk(synth_n === 17'h0CA1, "inactive rewrite");
    wr(6'h1F, 32'h84);
    repeat (3) @(posedge mclk);
    chk(synth_n === 17'h19C6, "back to main");
    $display("test hop done");
    repeat (4) @(posedge mclk);
    n = 0;
    m = 0;
    for (k = 0; k < 60; k++) begin
      @(posedge mclk);
      if (system_clock_output_o !== 1'b0) n++;
      if (system_clock_output_oe === 1'b1) m++;
    end
    chk(n == 0 && m > 0 && m < 60, "open drain");
    $display("test open drain done");
    wr(6'h14, 32'h100);
    repeat (2200) @(posedge mclk);
    rdc(6'h10, 32'hF1, 32'hF1);
    chk(vco_seg === 4'hF, "auto segment");
    vco_high <= 1'b0;
    wr(6'h14, 32'h50);
    wr(6'h14, 32'h150);
    repeat (2200) @(posedge mclk);
    rdc(6'h10, 32'hF0, 32'h00);
    chk(vco_seg === 4'h0, "auto segment low");
    $display("test auto segment done");
    en <= 1'b0;
    serial_strap <= 1'b0;
    repeat (10) @(posedge mclk);
    en <= 1'b1;
    repeat (40) @(posedge mclk);
    rdc(6'h01, 32'hFF, 32'h02);
    rdc(6'h03, 32'hFF, 32'h61);
    rdc(6'h0E, 32'h80, 32'h00);
    wr(6'h01, 32'h06);
    chk(ana.gen2 === 1'b0, "protocol not gen2");
    wr(6'h17, 32'h200000);
    chk(ana.ext_src === 1'b0 && ana.ext_presc === 1'b0, "prescaler alone");
    $display("test preset done");
    wr(6'h09, 32'h0);
    wr(6'h16, 32'h332005);
    for (int sd = 0; sd < 4; sd++) begin
      wr(6'h15, sd[31:0]);
      ramp(1'b1, lens[sd]);
      rdc(6'h0E, 32'h04, 32'h04);
      ramp(1'b0, lens[sd]);
      rdc(6'h0E, 32'h04, 32'h00);
    end
    $display("test ramp done");
    wrap_up();
  end
endmodule
bind rfpc_top rfpc_chk rfpc_chk_inst (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .EN(EN),
  .SYSTEM_CLOCK_OUTPUT_O(SYSTEM_CLOCK_OUTPUT_O),
  .SYSTEM_CLOCK_OUTPUT_OE(SYSTEM_CLOCK_OUTPUT_OE), .RF_FIELD_ON(RF_FIELD_ON),
  .RF_RAMPING(RF_RAMPING), .SYNTH_N(SYNTH_N));
